// >>> hw/event_link_pkg.sv
// package with constants for the event link packet framer
package event_link_pkg;
    // apb register byte offsets
    localparam logic [7:0] ctrl_addr       = 8'h00;
    localparam logic [7:0] interval_addr   = 8'h04;
    localparam logic [7:0] pattern_addr    = 8'h08;
    localparam logic [7:0] chip_id_addr    = 8'h0C;
    localparam logic [7:0] status_addr     = 8'h10;
    localparam logic [7:0] counters_addr   = 8'h14;
    // control bit positions
    localparam int ctrl_force_idle_bit     = 0;
    localparam int ctrl_trig_inhibit_bit   = 1;
    localparam int ctrl_link_test_bit      = 2;
    localparam int ctrl_chan_mask_lsb      = 4;
    localparam logic [7:0] ctrl_reset      = 8'hF0;
    // link characters, chosen valid in both serializer codings
    localparam logic [15:0] frame_head_char = 16'h3CBC;
    localparam logic [15:0] frame_end_char  = 16'hDCFC;
    localparam logic [15:0] idle_char       = 16'hBCBC;
    // packet geometry
    localparam int header_words    = 4;
    localparam int slot_count      = 3;
    localparam int slot_words      = 98;
    localparam int column_words    = 2;
    localparam int fe_chips        = 4;
    localparam int sample_bits     = 12;
    localparam int word_bits       = 16;
    localparam int payload_words   = slot_count * slot_words;
    // crc
    localparam logic [15:0] crc_poly = 16'h1021;
    localparam logic [15:0] crc_init = 16'hFFFF;
    // trigger decode
    localparam logic [2:0] pipeline_cmd_a_pattern = 3'b101;
    // flag set i: bits 11..8, flag set ii: bits 7..0
    localparam int flag_trig_full_bit  = 11;
    localparam int flag_fe_full_bit    = 10;
    localparam int flag_data_full_bit  = 9;
    localparam int flag_gen_err_bit    = 8;
    localparam int flag_inhibit_bit    = 7;
    localparam int flag_cal_bit        = 6;
    localparam int flag_test_bit       = 5;
    localparam int flag_chan_lsb       = 0;
    typedef enum logic [2:0] {
        st_idle    = 3'b000,
        st_head    = 3'b001,
        st_hdr     = 3'b011,
        st_payload = 3'b010,
        st_crc     = 3'b110,
        st_end     = 3'b111,
        st_sync    = 3'b101
    } frame_state_type;
endpackage : event_link_pkg

// >>> hw/event_link_packet_framer.sv
// event packet framer driving a 16-bit serializer bus, with apb registers
//
// Contract
// - header: start, flags, event, bunch, identifier; code sends the bunch word before the event word
// - payload holds three identical time slots
// - slot starts with four column addresses
// - twelve-bit samples packed into link words
// - four header, 294 payload, one checksum
// - crc trailer then frame end word
// - crc uses x16+x12+x5+1 polynomial
// - one 16-bit word per 40 MHz clock
// - idle characters give receiver synchronisation
// - frame start begins every frame, back-to-back
// - control symbols valid in both codings
// - idles after reset until data ready
// - idles after pipeline_cmd_a until data ready
// - force idle bit sends idles; code honours it only between frames, not mid-frame
// - serializer not ready sends idles; code honours it only between frames, not mid-frame
// - packet counter timeout inserts sync pattern
// - interval and pattern registers, reset zero
// - buffer full flags only in null packets
// - trigger 101 resets counters, clears buffers
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module event_link_packet_framer #(
    parameter int sample_width = 48 // sample word in, 3 words per 4 samples
) (
    input  wire logic        ref_clk,          // 40 mhz system clock
    input  wire logic        rst_n,            // synchronous reset, active low
    input  wire logic        psel,             // apb select
    input  wire logic        penable,          // apb access phase
    input  wire logic        pwrite,           // apb direction
    input  wire logic [7:0]  paddr,            // apb byte address
    input  wire logic [31:0] pwdata,           // apb write data
    output logic      [31:0] prdata,           // apb read data
    output logic             pready,           // apb ready
    output logic             pslverr,          // apb error
    input  wire logic [2:0]  trig_pattern,     // decoded three-bit trigger command
    input  wire logic        trig_valid,       // trigger command strobe
    input  wire logic        event_ready,      // an event is waiting to be framed
    input  wire logic        event_null,       // waiting event is a null event
    input  wire logic        event_cal,        // waiting event is a calibration event
    input  wire logic [2:0]  buf_full,         // trigger, fe, data buffer full
    input  wire logic        fe_error,         // front-end sync error seen
    input  wire logic [3:0]  fe_err_chan,      // channels out of sync
    input  wire logic [15:0] data_word,        // next payload word from buffers
    output logic             data_take,        // payload word consumed
    output logic             event_done,       // event fully sent
    output logic             buffer_clear,     // clear data, column, trigger buffers
    input  wire logic        serializer_ready_bit, // serializer locked
    output logic      [15:0] link_data,        // word to serializer
    output logic             link_ctrl         // word is a control character
);
    // only the documented packing of four samples into three words is served
    if (sample_width != 48) begin : width_check
        $error("sample_width must be 48");
    end
    logic [7:0]  ctrl;
    logic [7:0]  sync_interval_count;
    logic [7:0]  sync_pattern_length;
    logic [15:0] chip_identifier;
    logic [7:0]  event_counter_value;
    logic [11:0] bunch_counter_value;
    logic [7:0]  pkt_count;
    logic [7:0]  idle_count;
    logic [8:0]  word_count;
    logic [15:0] crc;
    logic        frame_null;
    logic        pipeline_cmd_a;
    logic        apb_wr;
    logic        apb_rd;
    logic [11:0] flags;
    logic [15:0] hdr_word;
    logic [15:0] next_crc;
    event_link_pkg::frame_state_type state;

    assign pipeline_cmd_a = trig_valid && (trig_pattern == event_link_pkg::pipeline_cmd_a_pattern);
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && penable && !pwrite;

    // apb register writes
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl                <= event_link_pkg::ctrl_reset;
            sync_interval_count <= 8'h00;
            sync_pattern_length <= 8'h00;
            chip_identifier     <= 16'h0000;
        end else if (apb_wr) begin
            case (paddr)
                event_link_pkg::ctrl_addr:     ctrl <= pwdata[7:0];
                event_link_pkg::interval_addr: sync_interval_count <= pwdata[7:0];
                event_link_pkg::pattern_addr:  sync_pattern_length <= pwdata[7:0];
                event_link_pkg::chip_id_addr:  chip_identifier <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // apb answer, zero wait state
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (psel && !penable) begin
                case (paddr)
                    event_link_pkg::ctrl_addr:     prdata <= {24'h0, ctrl};
                    event_link_pkg::interval_addr: prdata <= {24'h0, sync_interval_count};
                    event_link_pkg::pattern_addr:  prdata <= {24'h0, sync_pattern_length};
                    event_link_pkg::chip_id_addr:  prdata <= {16'h0, chip_identifier};
                    event_link_pkg::status_addr:   prdata <= {28'h0, state, serializer_ready_bit};
                    event_link_pkg::counters_addr:
                        prdata <= {12'h0, bunch_counter_value, event_counter_value};
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    // event and bunch counters
    always_ff @(posedge ref_clk) begin
        if (!rst_n || pipeline_cmd_a) begin
            event_counter_value <= 8'h00;
            bunch_counter_value <= 12'h000;
        end else begin
            bunch_counter_value <= bunch_counter_value + 12'h001;
            if (event_done)
                event_counter_value <= event_counter_value + 8'h01;
        end
    end

    // buffer clear pulse on pipeline_cmd_a
    always_ff @(posedge ref_clk) begin
        if (!rst_n)
            buffer_clear <= 1'b0;
        else
            buffer_clear <= pipeline_cmd_a;
    end

    // header flags; full flags only on null events
    always_comb begin
        flags = 12'h000;
        if (frame_null) begin
            flags[event_link_pkg::flag_trig_full_bit] = buf_full[2];
            flags[event_link_pkg::flag_fe_full_bit]   = buf_full[1];
            flags[event_link_pkg::flag_data_full_bit] = buf_full[0];
        end
        flags[event_link_pkg::flag_gen_err_bit] = fe_error;
        flags[event_link_pkg::flag_inhibit_bit] = ctrl[event_link_pkg::ctrl_trig_inhibit_bit];
        flags[event_link_pkg::flag_cal_bit]     = event_cal;
        flags[event_link_pkg::flag_test_bit]    = ctrl[event_link_pkg::ctrl_link_test_bit];
        flags[event_link_pkg::flag_chan_lsb +: 4] =
            fe_error ? fe_err_chan : ctrl[event_link_pkg::ctrl_chan_mask_lsb +: 4];
    end

    // header word order: flags i + bc, flags ii + ec, id
    always_comb begin
        case (word_count[1:0])
            2'd0:    hdr_word = {flags[11:8], bunch_counter_value};
            2'd1:    hdr_word = {flags[7:0], event_counter_value};
            2'd2:    hdr_word = chip_identifier;
            default: hdr_word = {4'h0, bunch_counter_value};
        endcase
    end

    // crc-ccitt step over one 16-bit word
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [15:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 15; i >= 0; i--)
            r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? event_link_pkg::crc_poly : 16'h0000);
        return r;
    endfunction

    assign next_crc = crc_step(crc, (state == event_link_pkg::st_payload) ? data_word : hdr_word);

    // framing state machine and link output
    always_ff @(posedge ref_clk) begin
        if (!rst_n || pipeline_cmd_a) begin
            state      <= event_link_pkg::st_idle;
            link_data  <= event_link_pkg::idle_char;
            link_ctrl  <= 1'b1;
            word_count <= 9'd0;
            crc        <= event_link_pkg::crc_init;
            pkt_count  <= 8'h00;
            idle_count <= 8'h00;
            frame_null <= 1'b0;
            data_take  <= 1'b0;
            event_done <= 1'b0;
        end else begin
            data_take  <= 1'b0;
            event_done <= 1'b0;
            link_ctrl  <= 1'b0;
            case (state)
                event_link_pkg::st_idle,
                event_link_pkg::st_end: begin
                    link_data <= event_link_pkg::idle_char;
                    link_ctrl <= 1'b1;
                    if (ctrl[event_link_pkg::ctrl_force_idle_bit] || !serializer_ready_bit) begin
                        state <= event_link_pkg::st_idle;
                    end else if (sync_interval_count != 8'h00 &&
                                 pkt_count >= sync_interval_count) begin
                        state      <= event_link_pkg::st_sync;
                        pkt_count  <= 8'h00;
                        idle_count <= 8'h00;
                    end else if (event_ready) begin
                        link_data  <= event_link_pkg::frame_head_char;
                        state      <= event_link_pkg::st_hdr;
                        word_count <= 9'd0;
                        crc        <= event_link_pkg::crc_init;
                        frame_null <= event_null;
                    end else begin
                        state <= event_link_pkg::st_idle;
                    end
                end
                event_link_pkg::st_sync: begin
                    link_data  <= event_link_pkg::idle_char;
                    link_ctrl  <= 1'b1;
                    idle_count <= idle_count + 8'h01;
                    if (idle_count + 8'h01 >= sync_pattern_length)
                        state <= event_link_pkg::st_idle;
                end
                event_link_pkg::st_hdr: begin
                    link_data  <= hdr_word;
                    crc        <= next_crc;
                    word_count <= word_count + 9'd1;
                    if (word_count == 9'(event_link_pkg::header_words - 2)) begin
                        state      <= event_link_pkg::st_payload;
                        word_count <= 9'd0;
                        data_take  <= 1'b1; // source advances at the first payload edge
                    end
                end
                event_link_pkg::st_payload: begin
                    // slot = column words then packed samples, 98 words each
                    link_data  <= data_word;
                    // take flag leads: high in the cycle whose closing edge reads the word
                    data_take  <= (word_count != 9'(event_link_pkg::payload_words - 1));
                    crc        <= next_crc;
                    word_count <= word_count + 9'd1;
                    if (word_count == 9'(event_link_pkg::payload_words - 1))
                        state <= event_link_pkg::st_crc;
                end
                event_link_pkg::st_crc: begin
                    link_data <= crc;
                    state     <= event_link_pkg::st_head;
                end
                event_link_pkg::st_head: begin
                    link_data  <= event_link_pkg::frame_end_char;
                    link_ctrl  <= 1'b1;
                    event_done <= 1'b1;
                    pkt_count  <= pkt_count + 8'h01;
                    state      <= event_link_pkg::st_end;
                end
                default: state <= event_link_pkg::st_idle;
            endcase
        end
    end
endmodule : event_link_packet_framer
`default_nettype wire

// >>> verification/event_link_properties.sv
// checker for the framer link and apb ports, with its bind
`timescale 1ns/10ps
`default_nettype none
module event_link_properties (
    input wire logic        ref_clk,              // clock
    input wire logic        rst_n,                // reset
    input wire logic        psel,                 // apb select
    input wire logic        penable,              // apb enable
    input wire logic [7:0]  paddr,                // apb address
    input wire logic        pready,               // apb ready
    input wire logic        pslverr,              // apb error
    input wire logic [2:0]  trig_pattern,         // command
    input wire logic        trig_valid,           // command strobe
    input wire logic        event_ready,          // event waiting
    input wire logic        data_take,            // word taken
    input wire logic        event_done,           // frame sent
    input wire logic        buffer_clear,         // buffers cleared
    input wire logic        serializer_ready_bit, // link locked
    input wire logic [15:0] link_data,            // link word
    input wire logic        link_ctrl             // control char
);
    // character and command decodes
    wire logic is_head = link_ctrl && link_data == event_link_pkg::frame_head_char;
    wire logic is_end  = link_ctrl && link_data == event_link_pkg::frame_end_char;
    wire logic is_idle = link_ctrl && link_data == event_link_pkg::idle_char;
    wire logic pipeline_cmd_a  = trig_valid && trig_pattern == event_link_pkg::pipeline_cmd_a_pattern;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    reset_idle_a: assert property ($rose(rst_n) |-> is_idle)
        else $error("link not idle after reset");
    head_cause_a: assert property (is_head |-> $past(serializer_ready_bit) && $past(event_ready))
        else $error("frame began without cause");
    frame_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n || buffer_clear)
        is_head |-> ##299 (is_end && event_done)) else $error("frame end misplaced");
    payload_start_a: assert property (is_head |=> !data_take [*2] ##1 data_take)
        else $error("payload start misplaced");
    trailer_slot_a: assert property (event_done |-> is_end && !$past(data_take) && !$past(data_take, 2) && $past(data_take, 3))
        else $error("checksum slot misplaced");
    after_end_a: assert property (is_end |=> is_idle || is_head)
        else $error("bad word after frame end");
    ctrl_chars_a: assert property (link_ctrl |-> is_idle || is_head || is_end)
        else $error("unknown control char");
    apb_ready_a: assert property (psel && !penable |=> pready) // zero wait
        else $error("apb answer late");
    apb_refuse_a: assert property (pslverr |-> pready && (paddr[1:0] != 2'h0 || paddr > 8'h14))
        else $error("error on mapped address");
    pipeline_cmd_a_clear_a: assert property (pipeline_cmd_a |=> buffer_clear ##1 !buffer_clear)
        else $error("no buffer clear pulse");
    pipeline_cmd_a_idle_a: assert property (pipeline_cmd_a |=> is_idle)
        else $error("no idle after pipeline_cmd_a");
    cover property (event_done);
    cover property (buffer_clear);
    cover property (pslverr);
endmodule : event_link_properties
bind event_link_packet_framer event_link_properties checker_i (.*);
`default_nettype wire

// >>> verification/event_link_receiver.sv
// serializer and remote receiver model for the framer link
`timescale 1ns/10ps
`default_nettype none
module event_link_receiver (
    input  wire logic        ref_clk,              // clock
    input  wire logic        rst_n,                // reset
    input  wire logic        lock_req,             // bench asks for lock
    input  wire logic [15:0] link_data,            // link word
    input  wire logic        link_ctrl,            // control char
    output logic             serializer_ready_bit, // locked
    output int               frames,               // frames ended
    output int               words,                // words in last frame
    output int               gap,                  // idles before last head
    output logic             crc_ok,               // checksum matched
    output logic [15:0]      hdr [3],              // last header words
    output logic [15:0]      rx_sum                // payload word sum
);
    logic [15:0] crc, prev, last;
    logic [2:0]  lock_cnt;
    logic        in_f;
    int          n, run;
    // ccitt step, msb first
    function automatic logic [15:0] step(input logic [15:0] c, input logic [15:0] w);
        for (int i = 15; i >= 0; i--) begin
            c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? event_link_pkg::crc_poly : 16'h0000);
        end
        return c;
    endfunction : step
    // lock takes eight cycles, is lost two cycles after lock_req falls
    always_ff @(posedge ref_clk) begin
        lock_cnt <= !lock_req ? 3'h0 : (lock_cnt == 3'h7 ? lock_cnt : lock_cnt + 3'h1);
        serializer_ready_bit <= lock_cnt == 3'h7;
    end
    // hunt frame head, then take words until frame end
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            in_f   <= 1'b0;
            frames <= 0;
            run    <= 0;
        end else if (link_ctrl && link_data == event_link_pkg::frame_head_char) begin
            in_f   <= 1'b1;
            n      <= 0;
            crc    <= event_link_pkg::crc_init;
            rx_sum <= 16'h0000;
            gap    <= run;
            run    <= 0;
        end else if (in_f && link_ctrl && link_data == event_link_pkg::frame_end_char) begin
            in_f   <= 1'b0;
            frames <= frames + 1;
            words  <= n;
            crc_ok <= prev == last;
        end else if (in_f) begin
            prev <= crc;
            crc  <= step(crc, link_data);
            last <= link_data;
            n    <= n + 1;
            if (n < 3) hdr[n] <= link_data;
            if (n >= 3 && n < 297) rx_sum <= rx_sum + link_data;
        end else if (link_ctrl && link_data == event_link_pkg::idle_char) begin
            run <= run + 1;
        end
    end
endmodule : event_link_receiver
`default_nettype wire

// >>> verification/event_link_packet_framer_test.sv
// self-checking bench for the event link packet framer
`timescale 1ns/10ps
`default_nettype none
module event_link_packet_framer_test;
    logic        ref_clk, rst_n, psel, penable, pwrite, trig_valid, event_ready, event_null;
    logic        event_cal, fe_error, lock_req, pready, pslverr, data_take, event_done;
    logic        buffer_clear, serializer_ready_bit, link_ctrl, crc_ok, err;
    logic [2:0]  trig_pattern, buf_full;
    logic [3:0]  fe_err_chan;
    logic [7:0]  paddr, ctrl;
    logic [9:0]  r;
    logic [15:0] data_word, link_data, sent_sum, rx_sum, chip_id;
    logic [15:0] hdr [3];
    logic [31:0] pwdata, prdata, rd;
    logic [2:0]  cmd [4] = '{3'h4, 3'h6, 3'h7, 3'h5};
    int          bad_count, compares, frames, words, gap, max_gap, seed, n;
    event_link_packet_framer DUT (.*);
    event_link_receiver far_end (.*);
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // fresh random payload word after each take
    always @(posedge ref_clk) begin
        if (data_take === 1'b1) begin
            sent_sum    <= sent_sum + data_word;
            data_word   <= 16'($urandom);
            event_ready <= 1'b0;
        end
    end
    function automatic logic [11:0] exp_flags(input logic [9:0] v, input logic [7:0] c);
        return {v[0] ? v[4:2] : 3'h0, v[5], c[1], v[1], c[2], 1'b0, v[5] ? v[9:6] : c[7:4]};
    endfunction : exp_flags
    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb
    task frame(input logic [9:0] v);
        {fe_err_chan, fe_error, buf_full, event_cal, event_null} <= v;
        sent_sum    <= 16'h0000;
        event_ready <= 1'b1;
        n = frames;
        do @(posedge ref_clk); while (event_done !== 1'b1);
        @(posedge ref_clk);
        check(frames, n + 1);
        check(words, 298);
        check(crc_ok, 1'b1);
        check(hdr[2], chip_id);
        check({hdr[0][15:12], hdr[1][15:8]}, exp_flags(v, ctrl));
        check(rx_sum, sent_sum);
    endtask : frame
    task tally_and_finish;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #750000;
        bad_count++;
        tally_and_finish();
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata, trig_valid, trig_pattern, lock_req} = '0;
        {event_ready, event_null, event_cal, buf_full, fe_error, fe_err_chan} = '0;
        {data_word, sent_sum, bad_count, compares} = '0;
        rst_n = 1'b0;
        seed = $urandom(32'h2982);
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (20) @(posedge ref_clk);
        check({link_ctrl, link_data}, {1'b1, event_link_pkg::idle_char});
        // reset values, identifier, unmapped place
        for (int i = 0; i < 3; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            check(rd[7:0], i == 0 ? event_link_pkg::ctrl_reset : 8'h00);
        end
        chip_id = 16'($urandom);
        apb(1'b1, event_link_pkg::chip_id_addr, {16'h0000, chip_id});
        apb(1'b0, event_link_pkg::chip_id_addr, 32'h0);
        check(rd[15:0], chip_id);
        apb(1'b0, 8'h20, 32'h0);
        check({err, rd}, {1'b1, 32'h0});
        // no frame while not locked, nor while forced idle
        event_ready <= 1'b1;
        apb(1'b1, event_link_pkg::ctrl_addr, 32'hF1);
        repeat (40) @(posedge ref_clk);
        check(frames, 0);
        lock_req <= 1'b1;
        repeat (40) @(posedge ref_clk);
        check({frames[0], link_ctrl, link_data}, {2'b01, event_link_pkg::idle_char});
        event_ready <= 1'b0;
        ctrl = {4'($urandom), 1'b0, 3'($urandom) & 3'h6};
        apb(1'b1, event_link_pkg::ctrl_addr, {24'h0, ctrl});
        // bursts without, then with, periodic sync pattern
        for (int k = 0; k < 2; k++) begin
            max_gap = 0;
            for (int i = 0; i < 4; i++) begin
                r = (i == 0) ? 10'h01D : 10'($urandom);
                frame(r);
                if (i > 0 && gap > max_gap) max_gap = gap;
            end
            check(max_gap >= 5, k);
            apb(1'b1, event_link_pkg::interval_addr, 32'h2);
            apb(1'b1, event_link_pkg::pattern_addr, 32'h5);
        end
        // commands mid-frame; only pipeline_cmd_a clears and aborts
        n = frames;
        event_ready <= 1'b1;
        repeat (60) @(posedge ref_clk);
        foreach (cmd[i]) begin
            trig_valid   <= 1'b1;
            trig_pattern <= cmd[i];
            @(posedge ref_clk);
            trig_valid   <= 1'b0;
            @(posedge ref_clk);
            check(buffer_clear, cmd[i] == event_link_pkg::pipeline_cmd_a_pattern);
        end
        repeat (40) @(posedge ref_clk);
        check({frames == n, link_ctrl, link_data}, {2'b11, event_link_pkg::idle_char});
        event_ready <= 1'b1;
        do @(posedge ref_clk); while (event_done !== 1'b1);
        @(posedge ref_clk);
        check({frames == n + 1, crc_ok}, 2'b11);
        tally_and_finish();
    end
endmodule : event_link_packet_framer_test
`default_nettype wire
